// file: include/cpu_mode_status_config_pkg.sv
// shared constants and carrier types for the mode, status and config register set
package cpu_mode_status_config_pkg;

	// register byte addresses on the plain register port
	localparam logic [7:0] STATUS_OFFSET    = 8'h00;
	localparam logic [7:0] FAULT_VA_OFFSET  = 8'h04;
	localparam logic [7:0] CONFIG_OFFSET    = 8'h08;
	localparam logic [7:0] ERROR_PC_OFFSET  = 8'h0c;

	// processor status register fields
	localparam int CU_LSB    = 28;
	localparam int RP_BIT    = 27;
	localparam int FR_BIT    = 26;
	localparam int RE_BIT    = 25;
	localparam int BEV_BIT   = 22;
	localparam int TS_BIT    = 21;
	localparam int SRF_BIT   = 20;
	localparam int CH_BIT    = 18;
	localparam int CE_BIT    = 17;
	localparam int DE_BIT    = 16;
	localparam int IM_LSB    = 8;
	localparam int KX_BIT    = 7;
	localparam int SX_BIT    = 6;
	localparam int UX_BIT    = 5;
	localparam int KSU_LSB   = 3;
	localparam int ERL_BIT   = 2;
	localparam int EXL_BIT   = 1;
	localparam int IE_BIT    = 0;
	localparam logic [31:0] STATUS_WMASK    = 32'hfe57_ffff;
	localparam logic [31:0] STATUS_RESERVED = 32'h0188_0000;
	localparam logic [31:0] STATUS_RESET    = 32'h0040_0004;

	// privilege level codes
	localparam logic [1:0] KSU_KERNEL = 2'h0;
	localparam logic [1:0] KSU_SUPER  = 2'h1;
	localparam logic [1:0] KSU_USER   = 2'h2;

	// configuration register fields
	localparam int CFG_HW_LSB = 6;
	localparam int IC_LSB     = 9;
	localparam int DC_LSB     = 6;
	localparam int IB_BIT     = 5;
	localparam int DB_BIT     = 4;
	localparam int SCU_BIT    = 3;
	localparam int K0_LSB     = 0;
	localparam logic [5:0] CFG_SW_RESET    = 6'h02;
	localparam logic [2:0] K0_UNCACHED     = 3'h2;
	localparam logic [2:0] K0_CACHED_NONCO = 3'h3;
	localparam logic [4:0] CACHE_LOG2_BASE = 5'h0c;

	// reduced-power clock divide ratio
	localparam logic [3:0] LOW_POWER_DIV = 4'h4;

	// events reported by the processor core, same clock
	typedef struct packed {
		logic [7:0]  pending_int_bits;
		logic        tlb_shutdown;
		logic        soft_reset;
		logic        err_exc_take;
		logic [31:0] exc_pc;
		logic        exc_in_delay_slot;
		logic [31:0] branch_pc;
		logic        xlate_err;
		logic [31:0] xlate_vaddr;
		logic        l2_hit_op_done;
		logic        l2_hit;
		logic        cache_err_detect;
	} core_evt_t;

	// decoded controls back to the core
	typedef struct packed {
		logic [3:0] cop_usable;
		logic       fp_reg_32;
		logic       user_endian_swap;
		logic       addr64_en;
		logic       ops64_en;
		logic [1:0] cur_mode;
		logic       boot_vectors;
		logic       load_check_bits;
		logic       cache_err_exc;
		logic       int_req;
		logic [4:0] icache_log2;
		logic [4:0] dcache_log2;
		logic       iline_32;
		logic       dline_32;
		logic       sc_update_coherent;
		logic       kseg0_cached;
	} mode_ctrl_t;

endpackage

// file: logic/cpu_mode_status_config_regs.sv
// processor status, fault address, error return address and configuration registers
`timescale 1ns/10ps

module cpu_mode_status_config_regs
	import cpu_mode_status_config_pkg::*;
(
	// clock and reset
	input  wire logic                                     i_sys_clk,
	input  wire logic                                     i_rst_b,
	// register port
	input  wire logic [7:0]                               i_addr,
	input  wire logic [31:0]                              i_wdata,
	input  wire logic                                     i_wr,
	input  wire logic                                     i_rd,
	output logic      [31:0]                              o_rdata,
	// core side
	input  wire cpu_mode_status_config_pkg::core_evt_t    i_core,
	input  wire logic [25:0]                              i_cfg_strap,
	output cpu_mode_status_config_pkg::mode_ctrl_t        o_ctrl,
	output logic                                          o_core_clk_en,
	output logic      [31:0]                              o_error_pc
);
	import cpu_mode_status_config_pkg::*;

	logic [31:0] processor_status_reg;
	logic [31:0] fault_vaddr_reg;
	logic [31:0] cpu_config_reg;
	logic [31:0] error_return_pc_reg;
	logic [25:0] strap_meta_reg;
	logic [25:0] strap_sync_reg;
	logic [1:0]  strap_wait_reg;
	logic        reset_pc_pend_reg;
	logic [3:0]  div_cnt_reg;
	logic        wr_status;
	logic        wr_config;
	logic [1:0]  privilege_level;
	logic        kernel_mode;
	logic        super_mode;
	logic        user_mode;
	logic [7:0]  int_active;
	mode_ctrl_t  ctrl_next;
	logic [31:0] rdata_next;

	assign wr_status   = i_wr && (i_addr == STATUS_OFFSET);
	assign wr_config   = i_wr && (i_addr == CONFIG_OFFSET);
	assign privilege_level         = processor_status_reg[KSU_LSB +: 2];
	// either level flag forces kernel mode regardless of the privilege field
	assign kernel_mode = (privilege_level == KSU_KERNEL) || processor_status_reg[EXL_BIT] ||
		processor_status_reg[ERL_BIT];
	assign super_mode  = !kernel_mode && (privilege_level == KSU_SUPER);
	assign user_mode   = !kernel_mode && (privilege_level == KSU_USER);
	assign int_active  = processor_status_reg[IM_LSB +: 8] & i_core.pending_int_bits;

	// status register: hardware sets win over a software write in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			processor_status_reg <= STATUS_RESET;
		end else begin
			logic [31:0] st;
			st = processor_status_reg;
			if (wr_status) begin
				// reserved bits never store, tlb shutdown is read-only
				st = (st & ~STATUS_WMASK) | (i_wdata & STATUS_WMASK);
			end
			if (i_core.tlb_shutdown) begin
				st[TS_BIT] = 1'b1;
			end
			if (i_core.soft_reset) begin
				st[SRF_BIT] = 1'b1;
				st[BEV_BIT] = 1'b1;
			end
			if (i_core.err_exc_take || i_core.soft_reset) begin
				st[ERL_BIT] = 1'b1;
			end
			if (i_core.l2_hit_op_done) begin
				st[CH_BIT] = i_core.l2_hit;
			end
			processor_status_reg <= st & ~STATUS_RESERVED;
		end
	end

	// fault address: only translation errors load it, software cannot
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fault_vaddr_reg <= 32'h0000_0000;
		end else if (i_core.xlate_err) begin
			fault_vaddr_reg <= i_core.xlate_vaddr;
		end
	end

	// hard reset is caught at the first edge after release, since an async
	// reset may only load constants; the core presents the reset pc there
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			reset_pc_pend_reg <= 1'b1;
		end else begin
			reset_pc_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			error_return_pc_reg <= 32'h0000_0000;
		end else if (reset_pc_pend_reg || i_core.err_exc_take || i_core.soft_reset) begin
			// no delay-slot flag is kept, so the branch pc is the restart point
			error_return_pc_reg <= i_core.exc_in_delay_slot ?
				i_core.branch_pc : i_core.exc_pc;
		end
	end

	// strap pins come from outside: two flops before any use
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			strap_meta_reg <= 26'h000_0000;
			strap_sync_reg <= 26'h000_0000;
		end else begin
			strap_meta_reg <= i_cfg_strap;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// straps are valid in the synchroniser two edges after release
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			strap_wait_reg <= 2'h3;
		end else if (strap_wait_reg != 2'h0) begin
			strap_wait_reg <= strap_wait_reg - 2'h1;
		end
	end

	// configuration: upper field latched once from straps, lower field software
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cpu_config_reg <= {26'h000_0000, CFG_SW_RESET};
		end else begin
			if (strap_wait_reg == 2'h1) begin
				cpu_config_reg[31:CFG_HW_LSB] <= strap_sync_reg;
			end
			if (wr_config) begin
				cpu_config_reg[CFG_HW_LSB-1:0] <= i_wdata[CFG_HW_LSB-1:0];
			end
		end
	end

	// reduced power: core advances on one cycle in LOW_POWER_DIV
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_cnt_reg   <= 4'h0;
			o_core_clk_en <= 1'b1;
		end else if (processor_status_reg[RP_BIT]) begin
			div_cnt_reg   <= (div_cnt_reg == LOW_POWER_DIV - 4'h1) ? 4'h0 : div_cnt_reg + 4'h1;
			o_core_clk_en <= (div_cnt_reg == LOW_POWER_DIV - 4'h1);
		end else begin
			div_cnt_reg   <= 4'h0;
			o_core_clk_en <= 1'b1;
		end
	end

	// decoded controls
	always_comb begin
		ctrl_next                 = '0;
		ctrl_next.cop_usable      = processor_status_reg[CU_LSB +: 4];
		ctrl_next.cop_usable[0]   = processor_status_reg[CU_LSB] || kernel_mode;
		ctrl_next.fp_reg_32       = processor_status_reg[FR_BIT];
		ctrl_next.user_endian_swap = processor_status_reg[RE_BIT] && user_mode;
		ctrl_next.addr64_en       = kernel_mode ? processor_status_reg[KX_BIT] :
			super_mode ? processor_status_reg[SX_BIT] :
			processor_status_reg[UX_BIT];
		ctrl_next.ops64_en        = kernel_mode ? 1'b1 :
			super_mode ? processor_status_reg[SX_BIT] :
			processor_status_reg[UX_BIT];
		ctrl_next.cur_mode        = kernel_mode ? KSU_KERNEL : privilege_level;
		ctrl_next.boot_vectors    = processor_status_reg[BEV_BIT];
		ctrl_next.load_check_bits = processor_status_reg[CE_BIT];
		ctrl_next.cache_err_exc   = i_core.cache_err_detect &&
			!processor_status_reg[DE_BIT];
		ctrl_next.int_req         = (|int_active) && processor_status_reg[IE_BIT] &&
			!processor_status_reg[EXL_BIT] && !processor_status_reg[ERL_BIT];
		ctrl_next.icache_log2     = CACHE_LOG2_BASE +
			{2'h0, cpu_config_reg[IC_LSB +: 3]};
		ctrl_next.dcache_log2     = CACHE_LOG2_BASE +
			{2'h0, cpu_config_reg[DC_LSB +: 3]};
		ctrl_next.iline_32        = cpu_config_reg[IB_BIT];
		ctrl_next.dline_32        = cpu_config_reg[DB_BIT];
		ctrl_next.sc_update_coherent = cpu_config_reg[SCU_BIT];
		// any code other than 3 is treated as uncached, the safe choice
		ctrl_next.kseg0_cached    = (cpu_config_reg[K0_LSB +: 3] == K0_CACHED_NONCO);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ctrl     <= '0;
			o_error_pc <= 32'h0000_0000;
		end else begin
			o_ctrl     <= ctrl_next;
			o_error_pc <= error_return_pc_reg;
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (i_addr)
			STATUS_OFFSET:   rdata_next = processor_status_reg;
			FAULT_VA_OFFSET: rdata_next = fault_vaddr_reg;
			CONFIG_OFFSET:   rdata_next = cpu_config_reg;
			ERROR_PC_OFFSET: rdata_next = error_return_pc_reg;
			default:         rdata_next = 32'h0000_0000;
		endcase
	end

	// read data stands for one cycle after each cycle of the read strobe, zero otherwise
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= i_rd ? rdata_next : 32'h0000_0000;
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	sequence status_write_s;
		i_wr && (i_addr == STATUS_OFFSET) && !i_core.soft_reset && !i_core.err_exc_take
			&& !i_core.l2_hit_op_done;
	endsequence

	sequence status_read_s;
		i_rd && (i_addr == STATUS_OFFSET) && !i_wr;
	endsequence

	status_rw_a: assert property (
		status_write_s ##1 status_read_s |=>
			(o_rdata & STATUS_WMASK & ~32'h0010_0000) ==
			($past(i_wdata, 2) & STATUS_WMASK & ~32'h0010_0000))
		else $error("status write not read back");

	reserved_zero_a: assert property (
		(processor_status_reg & STATUS_RESERVED) == 32'h0000_0000)
		else $error("reserved status bits not zero");

	cop_zero_kernel_a: assert property (
		kernel_mode |=> o_ctrl.cop_usable[0])
		else $error("coprocessor zero unusable in kernel");

	int_gate_a: assert property (
		(processor_status_reg[EXL_BIT] || processor_status_reg[ERL_BIT] ||
			!processor_status_reg[IE_BIT]) |=> !o_ctrl.int_req)
		else $error("interrupt raised while gated");

	int_raise_a: assert property (
		(|int_active && processor_status_reg[IE_BIT] && !processor_status_reg[EXL_BIT]
			&& !processor_status_reg[ERL_BIT]) |=> o_ctrl.int_req)
		else $error("enabled pending interrupt not raised");

	endian_user_a: assert property (
		!user_mode |=> !o_ctrl.user_endian_swap)
		else $error("endian swap outside user mode");

	tlb_sticky_a: assert property (
		i_core.tlb_shutdown |=> processor_status_reg[TS_BIT] [*3])
		else $error("tlb shutdown flag not held");

	fault_capture_a: assert property (
		i_core.xlate_err |=> fault_vaddr_reg == $past(i_core.xlate_vaddr))
		else $error("fault address not captured");

	error_pc_a: assert property (
		(i_core.err_exc_take && i_core.exc_in_delay_slot) |=> ##1
			o_error_pc == $past(i_core.branch_pc, 2))
		else $error("error pc not branch pc for delay slot");

	cache_err_a: assert property (
		processor_status_reg[DE_BIT] |=> !o_ctrl.cache_err_exc)
		else $error("cache error exception while disabled");

	cfg_ro_a: assert property (
		(wr_config && strap_wait_reg == 2'h0) |=>
			$stable(cpu_config_reg[31:CFG_HW_LSB]))
		else $error("config hardware field changed by write");

	low_power_a: assert property (
		(processor_status_reg[RP_BIT] && o_core_clk_en) [*1] ##1 processor_status_reg[RP_BIT]
			|-> !o_core_clk_en)
		else $error("core enable not slowed in low power");

endmodule

// file: dv/tb_cpu_mode_status_config_regs.sv
// self-checking bench for the mode, status and configuration register set
`timescale 1ns/10ps
module tb_cpu_mode_status_config_regs;
	import cpu_mode_status_config_pkg::*;
	logic        i_sys_clk;
	logic        i_rst_b;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [31:0] o_rdata;
	core_evt_t   core;
	core_evt_t   c;
	logic [25:0] i_cfg_strap;
	mode_ctrl_t  o_ctrl;
	logic        o_core_clk_en;
	logic [31:0] o_error_pc;
	logic        rd_d;
	logic [31:0] exp_q[$];
	logic [31:0] st, cfg, epc, v;
	logic [31:0] rs = 32'h0000_a512;
	int          num_errors = 0;
	int          compares = 0;
	int          cnt;

	cpu_mode_status_config_regs dut_u (
		.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_core(core),
		.i_cfg_strap(i_cfg_strap), .o_ctrl(o_ctrl), .o_core_clk_en(o_core_clk_en),
		.o_error_pc(o_error_pc));

	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// expected decode, from the bench's own copy of status and config
	function automatic mode_ctrl_t exp_ctrl();
		mode_ctrl_t e;
		logic [1:0] m;
		m = (st[ERL_BIT] | st[EXL_BIT]) ? KSU_KERNEL : st[KSU_LSB +: 2];
		e.cop_usable = st[CU_LSB +: 4] | {3'h0, m == KSU_KERNEL};
		e.fp_reg_32 = st[FR_BIT];
		e.user_endian_swap = st[RE_BIT] & (m == KSU_USER);
		e.addr64_en = (m == KSU_KERNEL) ? st[KX_BIT] : (m == KSU_SUPER) ? st[SX_BIT] : st[UX_BIT];
		e.ops64_en = (m == KSU_KERNEL) ? 1'b1 : (m == KSU_SUPER) ? st[SX_BIT] : st[UX_BIT];
		e.cur_mode = m;
		e.boot_vectors = st[BEV_BIT];
		e.load_check_bits = st[CE_BIT];
		e.cache_err_exc = core.cache_err_detect & ~st[DE_BIT];
		e.int_req = st[IE_BIT] & ~st[EXL_BIT] & ~st[ERL_BIT]
			& (|(st[IM_LSB +: 8] & core.pending_int_bits));
		e.icache_log2 = CACHE_LOG2_BASE + {2'h0, cfg[IC_LSB +: 3]};
		e.dcache_log2 = CACHE_LOG2_BASE + {2'h0, cfg[DC_LSB +: 3]};
		e.iline_32 = cfg[IB_BIT];
		e.dline_32 = cfg[DB_BIT];
		e.sc_update_coherent = cfg[SCU_BIT];
		e.kseg0_cached = cfg[K0_LSB +: 3] == K0_CACHED_NONCO;
		return e;
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// one bus cycle; strobes stay as set until the next call
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= d;
	endtask

	// the read strobe is one cycle: a held strobe would read again with no note queued
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		op(1'b0, 1'b1, a, xs());
		op(1'b0, 1'b0, 8'h00, 32'h0);
	endtask

	task automatic idle_chk();
		op(1'b0, 1'b0, 8'h00, xs());
		@(posedge i_sys_clk);
		#1;
		chk({4'h0, o_ctrl}, {4'h0, exp_ctrl()});
		chk(o_error_pc, epc);
	endtask

	// one core event for one cycle, then back to the held levels
	task automatic ev(input core_evt_t n);
		core_evt_t old;
		old = core;
		@(posedge i_sys_clk);
		core <= n;
		@(posedge i_sys_clk);
		core <= old;
	endtask

	always @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_d <= 1'b0;
		end else begin
			rd_d <= i_rd;
		end
	end

	// read data is looked at only in the cycle after the strobe, zero elsewhere
	always @(negedge i_sys_clk) begin
		if (i_rst_b && rd_d && exp_q.size() > 0) begin
			chk(o_rdata, exp_q.pop_front());
		end else if (i_rst_b) begin
			chk(o_rdata, 32'h0);
		end
	end

	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	initial begin
		#100000;
		num_errors++;
		give_verdict();
	end

	initial begin
		i_rst_b = 1'b0;
		{i_addr, i_wdata, i_wr, i_rd} = '0;
		core = '0;
		core.exc_pc = xs();
		v = xs();
		i_cfg_strap = v[25:0];
		epc = core.exc_pc;
		st = STATUS_RESET;
		cfg = {i_cfg_strap, CFG_SW_RESET};
		repeat (16) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		rd(STATUS_OFFSET, st);
		rd(CONFIG_OFFSET, cfg);
		rd(ERROR_PC_OFFSET, epc);
		idle_chk();
		for (int i = 0; i < 40; i++) begin
			v = xs();
			core.pending_int_bits <= v[7:0];
			core.cache_err_detect <= v[31];
			// reserved bits are written as zero; privilege code 11 is left out
			v = xs() & ~STATUS_RESERVED;
			if (v[KSU_LSB +: 2] == 2'h3) begin
				v[KSU_LSB] = 1'b0;
			end
			op(1'b1, 1'b0, CONFIG_OFFSET, xs());
			cfg[5:0] = rs[5:0];
			// status read follows its write with no gap, so the read-back check fires
			op(1'b1, 1'b0, STATUS_OFFSET, v);
			st = (v & STATUS_WMASK) | (st & 32'h0020_0000);
			rd(STATUS_OFFSET, st);
			rd(CONFIG_OFFSET, cfg);
			idle_chk();
		end
		op(1'b1, 1'b0, 8'h10, xs());
		rd(8'h10, 32'h0);
		c = core;
		c.xlate_err = 1'b1;
		c.xlate_vaddr = xs();
		ev(c);
		op(1'b1, 1'b0, FAULT_VA_OFFSET, xs());
		rd(FAULT_VA_OFFSET, c.xlate_vaddr);
		c = core;
		c.err_exc_take = 1'b1;
		c.exc_in_delay_slot = 1'b1;
		c.exc_pc = xs();
		c.branch_pc = xs();
		ev(c);
		epc = c.branch_pc;
		st[ERL_BIT] = 1'b1;
		rd(ERROR_PC_OFFSET, epc);
		rd(STATUS_OFFSET, st);
		c = core;
		c.soft_reset = 1'b1;
		c.exc_pc = xs();
		ev(c);
		epc = c.exc_pc;
		st = st | (32'h1 << SRF_BIT) | (32'h1 << BEV_BIT) | (32'h1 << ERL_BIT);
		rd(STATUS_OFFSET, st);
		idle_chk();
		c = core;
		c.tlb_shutdown = 1'b1;
		ev(c);
		op(1'b1, 1'b0, STATUS_OFFSET, 32'h0);
		st = 32'h0020_0000;
		rd(STATUS_OFFSET, st);
		for (int h = 1; h >= 0; h--) begin
			c = core;
			c.l2_hit_op_done = 1'b1;
			c.l2_hit = h[0];
			ev(c);
			st[CH_BIT] = h[0];
			rd(STATUS_OFFSET, st);
		end
		// the count window is a multiple of the divide ratio, so phase does not matter
		for (int k = 1; k >= 0; k--) begin
			st[RP_BIT] = k[0];
			op(1'b1, 1'b0, STATUS_OFFSET, st);
			op(1'b0, 1'b0, 8'h00, 32'h0);
			repeat (4) @(posedge i_sys_clk);
			cnt = 0;
			repeat (40) begin
				@(posedge i_sys_clk);
				#1;
				cnt += int'(o_core_clk_en);
			end
			chk(32'(cnt), k ? 32'(40 / int'(LOW_POWER_DIV)) : 32'd40);
		end
		idle_chk();
		give_verdict();
	end
endmodule
